//--- logic/mrs_pkg.sv
// Shared constants for the mode register link and its two ends
package mrs_pkg;
   // Register select codes on the command bus
   localparam logic [3:0] SEL_TERM_EXT = 4'h8;
   localparam logic [3:0] SEL_WCK_REF  = 4'hA;

   // termination_latency_ext field positions
   localparam int OP_CAL_LSB   = 0;
   localparam int OP_UPR_LSB   = 2;
   localparam int OP_OVERRIDE  = 4;
   localparam int OP_EDC_HIZ   = 5;
   localparam int OP_CLOCK_AUTO_CALIBRATION     = 6;
   localparam int OP_REF_PAIR  = 7;
   localparam int OP_RL_EXT    = 8;
   localparam int OP_WR_EXT    = 9;
   localparam int OP_CKT_LSB   = 10;

   // write_clock_ref_offset field positions
   localparam int OP_REF_OFS_LSB = 0;
   localparam int OP_WCK0_LSB    = 4;
   localparam int OP_WCK1_LSB    = 6;
   localparam int OP_TRAIN       = 8;
   localparam int OP_ZERO_BIT    = 9;
   localparam int OP_WCKT_LSB    = 10;

   // Termination codes
   localparam logic [1:0] TERM_OFF      = 2'h0;
   localparam logic [1:0] TERM_60       = 2'h1;
   localparam logic [1:0] TERM_120      = 2'h2;
   localparam logic [1:0] TERM_CODE3    = 2'h3;
   localparam logic [1:0] CKT_AT_RESET  = 2'h0;
   localparam logic [1:0] CKT_DISABLED  = 2'h3;
   localparam logic [3:0] REF_OFS_ZERO2 = 4'h8;

   // Reset values
   localparam logic [11:0] TERM_EXT_RESET = 12'h000;
   localparam logic [11:0] WCK_REF_RESET  = 12'h000;

   // Timing: mode command spacing and mode change delay
   localparam int CLK_MHZ           = 50;
   localparam int MODE_SPACING_NS   = 10;
   localparam int MODE_CHANGE_NS    = 200;
   localparam int MODE_SPACING_RAW  = (MODE_SPACING_NS * CLK_MHZ + 999) / 1000;
   localparam int MODE_CHANGE_RAW   = (MODE_CHANGE_NS * CLK_MHZ + 999) / 1000;
   localparam int MODE_SPACING_CYC  = (MODE_SPACING_RAW < 1) ? 1
                                      : MODE_SPACING_RAW;
   localparam int MODE_CHANGE_CYC   = (MODE_CHANGE_RAW < 1) ? 1
                                      : MODE_CHANGE_RAW;

   // Controller register map (byte addresses)
   localparam logic [7:0] CMD_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int ST_BUSY    = 0;
   localparam int ST_REFUSED = 1;
endpackage : mrs_pkg

//--- logic/mrs_link_if.sv
// Mode register set link between memory controller and device
`timescale 1ns/10ps
`default_nettype none
interface mrs_link_if (
   input wire logic clk
);
   logic        cmd_valid;
   logic [3:0]  sel;
   logic [11:0] op;
   logic [1:0]  ck_strap;

   modport device (
      input cmd_valid,
      input sel,
      input op,
      input ck_strap
   );
   modport host (
      output cmd_valid,
      output sel,
      output op,
      output ck_strap
   );
endinterface : mrs_link_if
`default_nettype wire

//--- logic/mode_reg_device.sv
// Device end: decodes and holds the two extension mode registers
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - Select 1000 writes termination/latency register
// R2 - Termination override cleared at initialization
// R3 - Low command termination from op 1:0
// R4 - High command termination from op 3:2
// R5 - Override zero ignores command termination writes
// R6 - Host waits mode-change delay after termination
// R7 - Error-detect high-impedance floats outputs, top priority
// R8 - Bit 6 allows clock impedance update
// R9 - Clock calibration ignored when off/disabled
// R10 - Bit 7 picks single or paired refresh
// R11 - Bit 8 is read latency MSB
// R12 - Bit 9 is write recovery MSB
// R13 - Clock termination field, 00 uses strap
// R14 - Non-programmable clock termination ignores writes
// R15 - Host programs both channels identically
// R16 - Host waits mode-change delay after clock termination
// R17 - Select 1010 writes write-clock/offset register
// R18 - Write-clock termination and offset cleared initially
// R19 - Offset decode; 1000 means zero
// R20 - Per-byte write-clock phase invert/shift
// R21 - Write-clock termination and training enable
// R22 - Host keeps bit 9 zero, no reserved
// R23 - Half reference mode suppresses offset
module mode_reg_device #(
   parameter logic [1:0] INIT_CAL_TERM = mrs_pkg::TERM_60,
   parameter logic [1:0] INIT_UPR_TERM = mrs_pkg::TERM_60,
   parameter bit         CK_TERM_PROG  = 1'b1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   mrs_link_if.device       link,
   input  wire logic        half_cmd_ref,
   input  wire logic        cal_updates_off,
   input  wire logic        all_bank_refresh,
   input  wire logic        refresh_cmd,
   input  wire logic        refresh_ca4_low,
   input  wire logic [3:0]  read_latency_field,
   input  wire logic [3:0]  write_recovery_field,
   output logic [1:0]       cal_term,
   output logic [1:0]       high_cmd_termination,
   output logic             error_detect_hiz,
   output logic             ck_imp_update,
   output logic             other_imp_update,
   output logic             single_bank_refresh,
   output logic             paired_bank_refresh,
   output logic [4:0]       read_latency,
   output logic [4:0]       write_recovery,
   output logic [1:0]       ck_term,
   output logic [3:0]       ref_offset_step,
   output logic [1:0]       wck_phase0,
   output logic [1:0]       wck_phase1,
   output logic             write_clock_training,
   output logic [1:0]       wck_term
);
   import mrs_pkg::*;

   logic [11:0] term_ext_reg;
   logic [11:0] wck_ref_reg;
   logic [1:0]  cal_term_reg;
   logic [1:0]  upr_term_reg;
   logic [1:0]  strap_reg;
   logic        strap_taken_reg;
   logic        ck_term_off;
   logic        wr_term_ext;
   logic        wr_wck_ref;

   assign wr_term_ext = link.cmd_valid && (link.sel == SEL_TERM_EXT); // R1
   assign wr_wck_ref  = link.cmd_valid && (link.sel == SEL_WCK_REF);  // R17

   // Strap is caught on the first edge after reset release, never in reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_taken_reg <= 1'b0;
         strap_reg       <= TERM_OFF;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         strap_reg       <= link.ck_strap; // R13
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         term_ext_reg <= TERM_EXT_RESET; // R2
      end else if (wr_term_ext) begin
         term_ext_reg <= link.op; // R1
         if (!CK_TERM_PROG) begin
            // Field keeps its init value, writes dropped
            term_ext_reg[OP_CKT_LSB +: 2] <= CKT_AT_RESET; // R14
         end
      end
   end

   // Command termination keeps its power-up value until override allows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_term_reg <= INIT_CAL_TERM;
         upr_term_reg <= INIT_UPR_TERM;
      end else if (wr_term_ext && link.op[OP_OVERRIDE]) begin // R5
         cal_term_reg <= link.op[OP_CAL_LSB +: 2]; // R3
         upr_term_reg <= link.op[OP_UPR_LSB +: 2]; // R4
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wck_ref_reg <= WCK_REF_RESET; // R18
      end else if (wr_wck_ref) begin
         wck_ref_reg <= link.op; // R17
      end
   end

   // Clock termination is off when disabled by field or by the strap
   always_comb begin
      if (term_ext_reg[OP_CKT_LSB +: 2] == CKT_AT_RESET) begin
         ck_term_off = (strap_reg == CKT_DISABLED);
      end else begin
         ck_term_off = (term_ext_reg[OP_CKT_LSB +: 2] == CKT_DISABLED);
      end
   end

   // Decoded termination and latency settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_term             <= INIT_CAL_TERM;
         high_cmd_termination <= INIT_UPR_TERM;
         error_detect_hiz     <= 1'b0;
         read_latency         <= 5'h00;
         write_recovery       <= 5'h00;
         ck_term              <= TERM_OFF;
      end else begin
         cal_term             <= cal_term_reg; // R3
         high_cmd_termination <= upr_term_reg; // R4
         // Float wins over any pattern source downstream
         error_detect_hiz     <= term_ext_reg[OP_EDC_HIZ]; // R7
         read_latency         <= {term_ext_reg[OP_RL_EXT],
                                  read_latency_field}; // R11
         write_recovery       <= {term_ext_reg[OP_WR_EXT],
                                  write_recovery_field}; // R12
         if (term_ext_reg[OP_CKT_LSB +: 2] == CKT_AT_RESET) begin
            ck_term <= strap_reg; // R13
         end else begin
            ck_term <= term_ext_reg[OP_CKT_LSB +: 2]; // R13
         end
      end
   end

   // Calibration update strobes during all-bank refresh
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_imp_update    <= 1'b0;
         other_imp_update <= 1'b0;
      end else begin
         other_imp_update <= all_bank_refresh && !cal_updates_off; // R8
         ck_imp_update    <= all_bank_refresh && !cal_updates_off
                             && !ck_term_off
                             && term_ext_reg[OP_CLOCK_AUTO_CALIBRATION]; // R9
      end
   end

   // Refresh with CA4 low goes single or paired by bit 7
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         single_bank_refresh <= 1'b0;
         paired_bank_refresh <= 1'b0;
      end else begin
         single_bank_refresh <= refresh_cmd && refresh_ca4_low
                                && !term_ext_reg[OP_REF_PAIR]; // R10
         paired_bank_refresh <= refresh_cmd && refresh_ca4_low
                                && term_ext_reg[OP_REF_PAIR]; // R10
      end
   end

   // Write-clock and reference offset settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_offset_step      <= 4'h0;
         wck_phase0           <= 2'h0;
         wck_phase1           <= 2'h0;
         write_clock_training <= 1'b0;
         wck_term             <= TERM_OFF;
      end else begin
         // Codes above 1000 are already two's complement of -7..-1
         if (half_cmd_ref
             || wck_ref_reg[OP_REF_OFS_LSB +: 4] == REF_OFS_ZERO2) begin
            ref_offset_step <= 4'h0; // R19 R23
         end else begin
            ref_offset_step <= wck_ref_reg[OP_REF_OFS_LSB +: 4]; // R19
         end
         wck_phase0           <= wck_ref_reg[OP_WCK0_LSB +: 2]; // R20
         wck_phase1           <= wck_ref_reg[OP_WCK1_LSB +: 2]; // R20
         write_clock_training <= wck_ref_reg[OP_TRAIN]; // R21
         wck_term             <= wck_ref_reg[OP_WCKT_LSB +: 2]; // R21
      end
   end
endmodule : mode_reg_device
`default_nettype wire

//--- logic/mode_reg_host.sv
// Host end: AHB-Lite slave that issues mode register set commands
`timescale 1ns/10ps
`default_nettype none
module mode_reg_host #(
   parameter logic [1:0] CK_STRAP = mrs_pkg::TERM_60
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   mrs_link_if.host         link
);
   import mrs_pkg::*;

   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [7:0]  gap_reg;
   logic        refused_reg;
   logic [11:0] shadow_reg;
   logic        shadow_valid_reg;
   logic        cmd_wr;
   logic        st_wr;
   logic        reserved_code;
   logic        term_change;
   logic [3:0]  new_sel;
   logic [11:0] new_op;

   assign cmd_wr  = wr_pend_reg && (wr_addr_reg == CMD_OFS);
   assign st_wr   = wr_pend_reg && (wr_addr_reg == STATUS_OFS);
   assign new_sel = hwdata[15:12];

   always_comb begin
      new_op = hwdata[11:0];
      if (new_sel == SEL_WCK_REF) begin
         new_op[OP_ZERO_BIT] = 1'b0; // R22
      end
   end

   assign reserved_code =
      ((new_sel == SEL_TERM_EXT)
       && new_op[OP_CAL_LSB +: 2] == TERM_CODE3)
      || ((new_sel == SEL_WCK_REF)
       && new_op[OP_WCKT_LSB +: 2] == TERM_CODE3); // R22

   // Unknown prior contents count as a change, which only costs time
   assign term_change = (new_sel == SEL_TERM_EXT)
      && (!shadow_valid_reg
          || new_op[OP_CKT_LSB +: 2] != shadow_reg[OP_CKT_LSB +: 2]
          || (new_op[OP_OVERRIDE]
              && new_op[3:0] != shadow_reg[3:0]));

   // Bus slave: zero wait states, OKAY always
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
         wr_addr_reg <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[7:0] == CMD_OFS) begin
               hrdata <= {20'h0_0000, shadow_reg};
            end else if (haddr[7:0] == STATUS_OFS) begin
               hrdata <= {30'h0000_0000, refused_reg, gap_reg != 8'h00};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Command issue and spacing between commands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.cmd_valid   <= 1'b0;
         link.sel         <= 4'h0;
         link.op          <= 12'h000;
         gap_reg          <= 8'h00;
         shadow_reg       <= 12'h000;
         shadow_valid_reg <= 1'b0;
      end else begin
         link.cmd_valid <= 1'b0;
         if (cmd_wr && gap_reg == 8'h00 && !reserved_code) begin
            link.cmd_valid <= 1'b1;
            link.sel       <= new_sel;
            link.op        <= new_op;
            if (term_change) begin
               gap_reg <= 8'(MODE_CHANGE_CYC); // R6 R15 R16
            end else begin
               gap_reg <= 8'(MODE_SPACING_CYC);
            end
            if (new_sel == SEL_TERM_EXT) begin
               shadow_reg       <= new_op;
               shadow_valid_reg <= 1'b1;
            end
         end else if (gap_reg != 8'h00) begin
            gap_reg <= gap_reg - 8'h01;
         end
      end
   end

   // Refused flag: set wins over write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refused_reg <= 1'b0;
      end else if (cmd_wr && (gap_reg != 8'h00 || reserved_code)) begin
         refused_reg <= 1'b1;
      end else if (st_wr && hwdata[ST_REFUSED]) begin
         refused_reg <= 1'b0;
      end
   end

   // Same strap on every channel keeps clock termination identical
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.ck_strap <= 2'h0;
      end else begin
         link.ck_strap <= CK_STRAP; // R15
      end
   end
endmodule : mode_reg_host
`default_nettype wire

//--- dv/mode_reg_link_properties.sv
// Link checker: command pulses, legal codes and command spacing
`timescale 1ns/10ps
`default_nettype none
module mode_reg_link_properties
   import mrs_pkg::*;
#(
   parameter logic [1:0] CK_STRAP = TERM_60
) (
   input wire logic        clk,
   input wire logic        hresetn,
   input wire logic        cmd_valid,
   input wire logic [3:0]  sel,
   input wire logic [11:0] op,
   input wire logic [1:0]  ck_strap
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!hresetn);

   logic       seen_reg;
   logic [1:0] ck_reg;
   logic [3:0] ca_reg;
   int         gap_reg;
   logic       wr8;
   logic       chg;

   assign wr8 = cmd_valid && sel == SEL_TERM_EXT;
   // First write after reset counts as a change: the strap may differ
   assign chg = wr8 && (!seen_reg || op[11:10] != ck_reg
                || (op[OP_OVERRIDE] && op[3:0] != ca_reg));

   always_ff @(posedge clk or negedge hresetn) begin
      if (!hresetn) begin
         seen_reg <= 1'b0;
         ck_reg <= 2'h0;
         ca_reg <= 4'h0;
      end else if (wr8) begin
         seen_reg <= 1'b1;
         ck_reg <= op[11:10];
         ca_reg <= op[3:0];
      end
   end

   always_ff @(posedge clk or negedge hresetn) begin
      if (!hresetn) begin
         gap_reg <= 0;
      end else if (chg) begin
         gap_reg <= MODE_CHANGE_CYC - 1;
      end else if (gap_reg != 0) begin
         gap_reg <= gap_reg - 1;
      end
   end

   a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse longer than one cycle");
   a_term_gap: assert property (cmd_valid |-> gap_reg == 0)
      else $error("command inside mode change delay");
   a_wck_bit9: assert property (cmd_valid && sel == SEL_WCK_REF
      |-> !op[OP_ZERO_BIT]) else $error("bit 9 set for write clock");
   a_wck_term_code: assert property (cmd_valid && sel == SEL_WCK_REF
      |-> op[11:10] != TERM_CODE3) else $error("reserved wck term sent");
   a_cal_term_code: assert property (wr8
      |-> op[1:0] != TERM_CODE3) else $error("reserved low term sent");
   a_op_holds: assert property (!cmd_valid |-> $stable(op))
      else $error("operand moved between commands");
   a_sel_holds: assert property (!cmd_valid |-> $stable(sel))
      else $error("select moved between commands");
   a_strap_value: assert property ($past(hresetn)
      |-> ck_strap == CK_STRAP) else $error("clock strap wrong");

   c_term_write: cover property (wr8);
   c_wck_write: cover property (cmd_valid && sel == SEL_WCK_REF);
   c_term_change: cover property (chg);
endmodule // mode_reg_link_properties
`default_nettype wire

//--- dv/sgram_mode_reg_8_10_decode_tb_top.sv
// Bench: AHB orders in, decoded mode register fields checked
`timescale 1ns/10ps
`default_nettype none
module sgram_mode_reg_8_10_decode_tb_top;
   import mrs_pkg::*;
   logic        hclk, hresetn, dev_rstn, hsel, hwrite, hreadyout, hresp;
   logic        half_cmd_ref, cal_updates_off, all_bank_refresh;
   logic        refresh_cmd, refresh_ca4_low, error_detect_hiz;
   logic        ck_imp_update, other_imp_update, write_clock_training;
   logic        single_bank_refresh, paired_bank_refresh;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, cal_term, high_cmd_termination, ck_term, wck_term;
   logic [1:0]  wck_phase0, wck_phase1;
   logic [2:0]  hsize;
   logic [3:0]  rl_field, wr_field, ref_offset_step;
   logic [4:0]  read_latency, write_recovery;
   logic [3:0]  ofs [4] = '{4'h7, 4'h8, 4'h9, 4'hF};
   logic [3:0]  ofs_exp [4] = '{4'h7, 4'h0, 4'h9, 4'hF};
   int          n_fail = 0;
   int          tests_run = 0;

   mrs_link_if i_mrs_link_if (.clk(hclk));
   mode_reg_host i_mode_reg_host (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .link(i_mrs_link_if));
   // Device leaves reset later so it latches the host strap
   mode_reg_device i_mode_reg_device (.hclk(hclk), .hresetn(dev_rstn),
      .link(i_mrs_link_if), .half_cmd_ref(half_cmd_ref),
      .cal_updates_off(cal_updates_off),
      .all_bank_refresh(all_bank_refresh), .refresh_cmd(refresh_cmd),
      .refresh_ca4_low(refresh_ca4_low), .read_latency_field(rl_field),
      .write_recovery_field(wr_field), .cal_term(cal_term),
      .high_cmd_termination(high_cmd_termination),
      .error_detect_hiz(error_detect_hiz), .ck_imp_update(ck_imp_update),
      .other_imp_update(other_imp_update),
      .single_bank_refresh(single_bank_refresh),
      .paired_bank_refresh(paired_bank_refresh),
      .read_latency(read_latency), .write_recovery(write_recovery),
      .ck_term(ck_term), .ref_offset_step(ref_offset_step),
      .wck_phase0(wck_phase0), .wck_phase1(wck_phase1),
      .write_clock_training(write_clock_training), .wck_term(wck_term));
   mode_reg_link_properties i_mode_reg_link_properties (.clk(hclk),
      .hresetn(hresetn), .cmd_valid(i_mrs_link_if.cmd_valid),
      .sel(i_mrs_link_if.sel), .op(i_mrs_link_if.op),
      .ck_strap(i_mrs_link_if.ck_strap));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task wait_idle;
      for (int k = 0; k < 40; k++) begin
         ahb(1'b0, 32'(STATUS_OFS), 32'h0000_0000);
         if (rd[ST_BUSY] === 1'b0) break;
      end
      if (rd[ST_BUSY] !== 1'b0) begin
         n_fail++;
         $display("mismatch at %0t: busy never cleared", $time);
      end
   endtask

   task mrs(input logic [3:0] s, input logic [11:0] o);
      wait_idle;
      ahb(1'b1, 32'(CMD_OFS), {16'h0000, s, o});
      wait_idle;
      repeat (2) @(posedge hclk);
      #1;
   endtask

   // Outputs are one-edge pulses, so look right after that edge
   task pulse(input logic c, input logic l, input logic a);
      @(posedge hclk);
      refresh_cmd <= c;
      refresh_ca4_low <= l;
      all_bank_refresh <= a;
      @(posedge hclk);
      refresh_cmd <= 1'b0;
      refresh_ca4_low <= 1'b0;
      all_bank_refresh <= 1'b0;
      #1;
   endtask

   initial begin
      {hsel, hwrite, half_cmd_ref, cal_updates_off} = 4'h0;
      {all_bank_refresh, refresh_cmd, refresh_ca4_low} = 3'h0;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      {hresetn, dev_rstn, rl_field, wr_field} = {2'b00, 4'h5, 4'hA};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      dev_rstn <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      chk({wck_term, ref_offset_step}, 6'h00);
      chk(ck_term, TERM_60);
      $display("test reset done");
      mrs(SEL_TERM_EXT, 12'h7EE);
      chk({cal_term, high_cmd_termination}, {TERM_60, TERM_60});
      chk(error_detect_hiz, 1'b1);
      chk(read_latency, 5'h15);
      chk(write_recovery, 5'h1A);
      chk(ck_term, TERM_60);
      pulse(1'b1, 1'b1, 1'b0);
      chk({single_bank_refresh, paired_bank_refresh}, 2'b01);
      mrs(4'h7, 12'h000);
      chk(error_detect_hiz, 1'b1);
      mrs(SEL_TERM_EXT, 12'hC56);
      chk({cal_term, high_cmd_termination}, {TERM_120, TERM_60});
      chk(ck_term, CKT_DISABLED);
      chk(read_latency, 5'h05);
      pulse(1'b0, 1'b0, 1'b1);
      chk({ck_imp_update, other_imp_update}, 2'b01);
      mrs(SEL_TERM_EXT, 12'h856);
      pulse(1'b1, 1'b1, 1'b0);
      chk({single_bank_refresh, paired_bank_refresh}, 2'b10);
      pulse(1'b0, 1'b0, 1'b1);
      chk({ck_imp_update, other_imp_update}, 2'b11);
      @(posedge hclk) cal_updates_off <= 1'b1;
      pulse(1'b0, 1'b0, 1'b1);
      chk({ck_imp_update, other_imp_update}, 2'b00);
      @(posedge hclk) cal_updates_off <= 1'b0;
      mrs(SEL_TERM_EXT, 12'h857);
      chk(cal_term, TERM_120);
      chk(rd[ST_REFUSED], 1'b1);
      ahb(1'b1, 32'(STATUS_OFS), 32'h0000_0002);
      ahb(1'b0, 32'(STATUS_OFS), 32'h0000_0000);
      chk(rd[ST_REFUSED], 1'b0);
      ahb(1'b0, 32'(CMD_OFS), 32'h0000_0000);
      chk(rd[11:0], 12'h856);
      chk({hresp, hreadyout}, 2'b01);
      ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Clock field change starts the long delay; the next order is dropped
      ahb(1'b1, 32'(CMD_OFS), {16'h0000, SEL_TERM_EXT, 12'h416});
      ahb(1'b1, 32'(CMD_OFS), {16'h0000, SEL_WCK_REF, 12'h000});
      ahb(1'b0, 32'(STATUS_OFS), 32'h0000_0000);
      chk(rd[1:0], 2'b11);
      pulse(1'b0, 1'b0, 1'b1);
      chk({ck_imp_update, other_imp_update}, 2'b01);
      $display("test termination done");
      for (int i = 0; i < 4; i++) begin
         mrs(SEL_WCK_REF, {2'((i + 1) % 3), 1'b0, i[0], 2'(3 - i),
             2'(i), ofs[i]});
         chk(ref_offset_step, ofs_exp[i]);
         chk({wck_phase1, wck_phase0}, {2'(3 - i), 2'(i)});
         chk({wck_term, write_clock_training},
             {2'((i + 1) % 3), i[0]});
      end
      @(posedge hclk) half_cmd_ref <= 1'b1;
      repeat (3) @(posedge hclk);
      #1;
      chk(ref_offset_step, 4'h0);
      @(posedge hclk) half_cmd_ref <= 1'b0;
      mrs(SEL_WCK_REF, 12'hC00);
      chk(wck_term, TERM_60);
      chk(ref_offset_step, 4'hF);
      $display("test write clock done");
      complete_run;
   end

   initial begin
      #400000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      complete_run;
   end
endmodule // sgram_mode_reg_8_10_decode_tb_top
`default_nettype wire
